// ---- src/vrh_ctrl.sv ----
/*
  host-side controller for the random port of a dual-port video dram:
  random read, early write, read-modify-write, page mode, transfers,
  cas-before-ras, row-only and hidden refresh, power-up sequence.
  assumes one 100 MHz clock; the data pins are resolved outside.
*/
`timescale 1ns/1ps
module vrh_ctrl import vrh_pkg::*; #(
  parameter int PAUSE_CYCLES = C_PAUSE
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire vrh_cmd_t cmd_in,
  output logic cmd_ready_out,
  input wire logic refresh_row_only_in,
  output logic [DQ_W-1:0] rdata_out,
  output logic rdata_valid_out,
  output logic init_done_out,
  output vrh_pins_t pins_out,
  input wire logic [DQ_W-1:0] mask_data_pins_in,
  output logic [DQ_W-1:0] mask_data_pins_out,
  output logic mask_data_pins_oe_n_out
);

  localparam vrh_regs_t REGS_RST = '{st: ST_INIT,
    cnt: CNT_W'(PAUSE_CYCLES - 1), init_left: '0, cmd: '0,
    pins: PINS_IDLE, dq_o: '0, dq_oe_n: 1'b1, dq_s1: '0, dq_s2: '0,
    rdata: '0, rvalid: 1'b0, ref_row: '0, buf_out: 1'b0};

  vrh_regs_t r;
  vrh_regs_t next_r;
  logic take;
  logic ref_need;
  logic ref_urgent;
  logic ref_done;
  logic ready_idle;
  logic page_ok;
  logic masked;

  function automatic logic is_xfer(input vrh_op_t op);
    return (op == OP_RD_XFER) || (op == OP_WR_XFER) || (op == OP_PS_XFER);
  endfunction

  function automatic logic is_rand(input vrh_op_t op);
    return (op == OP_READ) || (op == OP_WRITE) || (op == OP_RMW);
  endfunction

  vrh_refresh u_ref (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .done_in(ref_done),
    .need_out(ref_need),
    .urgent_out(ref_urgent)
  );

  assign ref_done = ce_in && (r.st == ST_CBR_R) && (r.cnt == '0);
  assign ready_idle = (r.st == ST_IDLE) && (r.init_left == '0) &&
    !ref_urgent && !((cmd_in.op == OP_WR_XFER) && r.buf_out);
  assign masked = cmd_in.use_mask &&
    ((cmd_in.op == OP_WRITE) || (cmd_in.op == OP_RMW));
  assign page_ok = (r.st == ST_END) && cmd_valid_in && !ref_urgent &&
    is_rand(cmd_in.op) && !cmd_in.use_mask && is_rand(r.cmd.op) &&
    (cmd_in.row == r.cmd.row);

  always_comb begin
    next_r = r;
    take = 1'b0;
    next_r.rvalid = 1'b0;
    next_r.dq_s1 = mask_data_pins_in;
    next_r.dq_s2 = r.dq_s1;
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    case (r.st)
      ST_INIT: begin
        if (r.cnt == '0) begin
          next_r.init_left = INIT_LEFT; // RULE_26
          next_r.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!ready_idle && (r.init_left != '0 || ref_urgent) ||
            ref_need && !cmd_valid_in) begin
          if (refresh_row_only_in && r.init_left == '0) begin
            next_r.cmd.op = OP_ROWREF; // RULE_17
            next_r.pins.addr = r.ref_row;
            next_r.st = ST_SETUP;
          end else begin
            next_r.cmd.op = OP_READ;
            next_r.pins.cas_n = 1'b0; // RULE_18
            next_r.cnt = CNT_W'(C_CSR - 1);
            next_r.st = ST_CBR_C;
          end
        end else if (cmd_valid_in && (cmd_in.op == OP_WR_XFER) &&
                     r.buf_out && r.init_left == '0 && !ref_urgent) begin
          next_r.cmd.op = OP_PS_XFER; // RULE_25
          next_r.cmd.row = cmd_in.row;
          next_r.cmd.col = cmd_in.col;
          next_r.pins.addr = cmd_in.row;
          next_r.pins.transfer_output_enable_n = 1'b0;
          next_r.pins.mask_select_write_enable_n = 1'b0;
          next_r.pins.serial_enable_n = 1'b1;
          next_r.st = ST_SETUP;
        end else if (cmd_valid_in && ready_idle) begin
          take = 1'b1;
          next_r.cmd = cmd_in;
          next_r.pins.addr = cmd_in.row; // RULE_01
          next_r.pins.transfer_output_enable_n = !is_xfer(cmd_in.op); // RULE_08
          next_r.pins.mask_select_write_enable_n = !(masked ||
            cmd_in.op == OP_WR_XFER || cmd_in.op == OP_PS_XFER); // RULE_20
          next_r.pins.serial_enable_n = (cmd_in.op != OP_WR_XFER); // RULE_20
          next_r.dq_o = cmd_in.mask; // RULE_12
          next_r.dq_oe_n = !masked;
          next_r.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_r.pins.ras_n = 1'b0; // RULE_02
        next_r.cnt = CNT_W'(C_RAH - 1);
        next_r.st = ST_RAS_LO;
      end
      ST_RAS_LO: begin
        if (r.cnt == '0) begin
          if (r.cmd.op == OP_ROWREF) begin
            next_r.cnt = CNT_W'(C_RAS - C_RAH - 1); // RULE_17
            next_r.st = ST_CBR_R;
          end else begin
            next_r.pins.addr = r.cmd.col; // RULE_01
            next_r.cnt = CNT_W'(C_ASC - 1);
            next_r.st = ST_COL;
            if (r.cmd.op == OP_WRITE) begin
              next_r.pins.mask_select_write_enable_n = 1'b0; // RULE_07
              next_r.dq_o = r.cmd.wdata; // RULE_10
              next_r.dq_oe_n = 1'b0;
            end else if (is_rand(r.cmd.op)) begin
              next_r.pins.mask_select_write_enable_n = 1'b1; // RULE_04
              next_r.dq_oe_n = 1'b1;
            end
          end
        end
      end
      ST_COL: begin
        if (r.cnt == '0) begin
          next_r.pins.cas_n = 1'b0; // RULE_02
          next_r.st = ST_CAS_LO;
          if (r.cmd.op == OP_READ || r.cmd.op == OP_RMW) begin
            next_r.pins.transfer_output_enable_n = 1'b0; // RULE_09
            next_r.cnt = CNT_W'(C_RD - 1);
          end else begin
            next_r.cnt = CNT_W'(C_CASW - 1); // RULE_03
          end
        end
      end
      ST_CAS_LO: begin
        if (r.cnt == '0) begin
          next_r.st = ST_END;
          if (r.cmd.op == OP_READ || r.cmd.op == OP_RMW) begin
            next_r.rdata = r.dq_s2;
            next_r.rvalid = 1'b1;
          end
          if (r.cmd.op == OP_RMW) begin
            next_r.pins.transfer_output_enable_n = 1'b1; // RULE_09
            next_r.cnt = CNT_W'(C_OED - 1);
            next_r.st = ST_RMW_W;
          end
        end
      end
      ST_RMW_W: begin
        if (r.cnt == '0) begin
          if (r.pins.mask_select_write_enable_n) begin
            next_r.pins.mask_select_write_enable_n = 1'b0; // RULE_09
            next_r.dq_o = r.cmd.wdata; // RULE_10
            next_r.dq_oe_n = 1'b0; // RULE_05
            next_r.cnt = CNT_W'(C_WP - 1);
          end else begin
            next_r.st = ST_END;
          end
        end
      end
      ST_END: begin
        next_r.pins.transfer_output_enable_n = 1'b1; // RULE_24
        next_r.st = ST_RISE;
        // ras kept low one more cycle so its minimum width is met
        if (r.cmd.op == OP_READ && ref_need) begin
          next_r.pins.transfer_output_enable_n = 1'b0; // RULE_19
          next_r.pins.ras_n = 1'b1; // RULE_19
          next_r.cnt = CNT_W'(C_RP - 1);
          next_r.st = ST_HID_P;
        end else if (page_ok) begin
          take = 1'b1;
          next_r.cmd = cmd_in;
          next_r.pins.cas_n = 1'b1; // RULE_11
          next_r.pins.mask_select_write_enable_n = 1'b1;
          next_r.dq_oe_n = 1'b1;
          next_r.cnt = CNT_W'(C_CP - 1);
          next_r.st = ST_RAS_LO;
        end
      end
      ST_HID_P: begin
        if (r.cnt == '0) begin
          next_r.pins.ras_n = 1'b0; // RULE_19
          next_r.cnt = CNT_W'(C_RAS - 1);
          next_r.st = ST_CBR_R;
        end
      end
      ST_CBR_C: begin
        if (r.cnt == '0) begin
          next_r.pins.ras_n = 1'b0; // RULE_18
          next_r.cnt = CNT_W'(C_RAS - 1);
          next_r.st = ST_CBR_R;
        end
      end
      ST_CBR_R: begin
        if (r.cnt == '0) begin
          next_r.pins.ras_n = 1'b1;
          next_r.st = ST_RISE;
          if (r.cmd.op == OP_ROWREF) begin
            next_r.ref_row = r.ref_row + 1'b1; // RULE_17
          end
          if (r.init_left != '0) begin
            next_r.init_left = r.init_left - 1'b1; // RULE_26
          end
        end
      end
      ST_RISE: begin
        if (r.cmd.op == OP_RD_XFER) begin
          next_r.buf_out = 1'b1; // RULE_22
        end else if (r.cmd.op == OP_PS_XFER || r.cmd.op == OP_WR_XFER) begin
          next_r.buf_out = 1'b0; // RULE_22
        end
        next_r.pins = PINS_IDLE; // RULE_28
        next_r.pins.addr = r.pins.addr;
        next_r.dq_oe_n = 1'b1;
        next_r.cnt = CNT_W'(C_RP - 1); // RULE_03
        next_r.st = ST_PRECH;
      end
      ST_PRECH: begin
        if (r.cnt == '0) begin
          next_r.st = ST_IDLE;
        end
      end
      default: begin
        next_r = REGS_RST;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= REGS_RST;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign cmd_ready_out = take && ce_in;
  assign rdata_out = r.rdata;
  assign rdata_valid_out = r.rvalid;
  assign init_done_out = (r.st != ST_INIT) && (r.init_left == '0);
  assign pins_out = r.pins;
  assign mask_data_pins_out = r.dq_o;
  assign mask_data_pins_oe_n_out = r.dq_oe_n;

  sequence s_row_open;
    $fell(r.pins.ras_n) && r.pins.cas_n;
  endsequence

  sequence s_read_cas;
    $fell(r.pins.cas_n) && !r.pins.ras_n && (r.cmd.op == OP_READ);
  endsequence

  no_contention_a: assert property (@(posedge clk_in) // RULE_05
    disable iff (rst_in) !r.dq_oe_n |-> r.pins.transfer_output_enable_n)
    else $error("data pins driven while device output enabled");

  precharge_min_a: assert property (@(posedge clk_in) // RULE_03
    disable iff (rst_in || !ce_in) $rose(r.pins.ras_n) |-> r.pins.ras_n[*8])
    else $error("row strobe precharge too short");

  ras_width_a: assert property (@(posedge clk_in) // RULE_03
    disable iff (rst_in || !ce_in) $fell(r.pins.ras_n) |-> !r.pins.ras_n[*8]
    ##1 !r.pins.ras_n[*2])
    else $error("row strobe pulse too short");

  xfer_decode_a: assert property (@(posedge clk_in) // RULE_20
    disable iff (rst_in) s_row_open and !r.pins.transfer_output_enable_n
    |-> is_xfer(r.cmd.op) && (r.pins.serial_enable_n ==
    (r.cmd.op != OP_WR_XFER)))
    else $error("transfer levels wrong at row strobe fall");

  random_oe_a: assert property (@(posedge clk_in) // RULE_08
    disable iff (rst_in) s_row_open and is_rand(r.cmd.op)
    |-> r.pins.transfer_output_enable_n)
    else $error("output enable low at row strobe fall of random access");

  mask_latch_a: assert property (@(posedge clk_in) // RULE_12
    disable iff (rst_in) s_row_open and is_rand(r.cmd.op) and
    !r.pins.mask_select_write_enable_n |-> !r.dq_oe_n &&
    r.dq_o == r.cmd.mask && r.cmd.use_mask)
    else $error("mask not presented at row strobe fall");

  early_write_a: assert property (@(posedge clk_in) // RULE_07
    disable iff (rst_in) $fell(r.pins.cas_n) && r.cmd.op == OP_WRITE
    |-> !r.pins.mask_select_write_enable_n && !r.dq_oe_n &&
    r.dq_o == r.cmd.wdata && $past(!r.pins.mask_select_write_enable_n))
    else $error("early write data or enable not set before cas");

  read_we_high_a: assert property (@(posedge clk_in) // RULE_04
    disable iff (rst_in || !ce_in) s_read_cas
    |-> r.pins.mask_select_write_enable_n[*6])
    else $error("write enable low during read");

  read_data_a: assert property (@(posedge clk_in) // RULE_09
    disable iff (rst_in || !ce_in) s_read_cas |-> ##6 r.rvalid)
    else $error("read data not returned six cycles after cas fall");

  cbr_setup_a: assert property (@(posedge clk_in) // RULE_18
    disable iff (rst_in) $fell(r.pins.ras_n) && !r.pins.cas_n
    |-> $past(!r.pins.cas_n))
    else $error("cas not set up before row strobe in refresh");

endmodule

// ---- src/vrh_pkg.sv ----
/*
  constants, command and pin carriers, state types for the video dram
  random-port host controller.
  assumes a 100 MHz clock; all timing counts derive from it.
*/
// Overview of operation
// RULE_01 - row half, then column half, nine bits each
// RULE_02 - row on ras fall, column on cas
// RULE_03 - honour strobe pulse widths and row precharge
// RULE_04 - read keeps write enable high throughout
// RULE_05 - device drives data only when cas, oe low
// RULE_06 - read data holds until cas rises
// RULE_07 - write enable before cas gives early write
// RULE_08 - oe high at ras fall for writes
// RULE_09 - rmw: oe read, then write enable write
// RULE_10 - write data valid by later falling edge
// RULE_11 - page mode toggles cas within one row
// RULE_12 - write enable low at ras latches mask
// RULE_13 - mask zero blocks bit, one allows
// RULE_14 - mask lasts one row cycle only
// RULE_15 - refresh all 512 rows every 8 ms
// RULE_16 - every row cycle refreshes the whole row
// RULE_17 - row-only refresh walks all row addresses
// RULE_18 - cas before ras uses internal counter
// RULE_19 - hidden refresh: hold cas, cycle ras
// RULE_20 - transfer type from strobe levels at ras
// RULE_21 - transfer moves a whole row, ports coupled
// RULE_22 - pseudo write sets direction, moves nothing
// RULE_23 - all modes decoded at ras fall
// RULE_24 - read transfer completes on oe rising
// RULE_25 - pseudo write before write after read transfer
// RULE_26 - power-up pause then eight init cycles
// RULE_27 - timer schedules refresh ahead when at risk
// RULE_28 - ras high idle means standby
package vrh_pkg;

  localparam int CLK_NS = 10;
  localparam int ROW_W = 9;
  localparam int COL_W = 9;
  localparam int DQ_W = 4;
  localparam int ROWS = 512;
  localparam int INIT_CYCLES = 8;
  localparam int SYNC_STAGES = 2;

  localparam int T_RAS_NS = 100;
  localparam int T_CAS_NS = 25;
  localparam int T_RP_NS = 80;
  localparam int T_RAH_NS = 15;
  localparam int T_ASC_NS = 10;
  localparam int T_CSR_NS = 10;
  localparam int T_OEA_NS = 25;
  localparam int T_OED_NS = 20;
  localparam int T_WP_NS = 20;
  localparam int T_CP_NS = 15;
  localparam int T_PAUSE_US = 200;
  localparam int T_REF_MS = 8;

  localparam int C_RAS = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CAS = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RAH = (T_RAH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_ASC = (T_ASC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CSR = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_OEA = (T_OEA_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_OED = (T_OED_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CP = (T_CP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_PAUSE = T_PAUSE_US * 1000 / CLK_NS;
  localparam int C_REFI = T_REF_MS * 1000000 / (ROWS * CLK_NS);
  // cas low long enough that the whole ras low time meets its minimum
  localparam int C_RAS_REST = C_RAS - C_RAH - C_ASC - 1;
  localparam int C_CASW = (C_RAS_REST > C_CAS) ? C_RAS_REST : C_CAS;
  localparam int C_RD_RAW = C_OEA + SYNC_STAGES + 1;
  localparam int C_RD = (C_RD_RAW > C_CASW) ? C_RD_RAW : C_CASW;

  localparam int CNT_W = 16;
  localparam int REFI_W = 11;
  localparam int PEND_W = 4;
  localparam logic [PEND_W-1:0] PEND_MAX = 4'h8;
  localparam logic [PEND_W-1:0] PEND_URGENT = 4'h6;
  localparam logic [3:0] INIT_LEFT = 4'h8;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RMW = 3'h2,
    OP_RD_XFER = 3'h3,
    OP_WR_XFER = 3'h4,
    OP_PS_XFER = 3'h5,
    OP_ROWREF = 3'h6
  } vrh_op_t;

  typedef enum logic [12:0] {
    ST_INIT = 13'h0001,
    ST_IDLE = 13'h0002,
    ST_SETUP = 13'h0004,
    ST_RAS_LO = 13'h0008,
    ST_COL = 13'h0010,
    ST_CAS_LO = 13'h0020,
    ST_RMW_W = 13'h0040,
    ST_END = 13'h0080,
    ST_HID_P = 13'h0100,
    ST_CBR_C = 13'h0200,
    ST_CBR_R = 13'h0400,
    ST_RISE = 13'h0800,
    ST_PRECH = 13'h1000
  } vrh_state_t;

  typedef struct packed {
    vrh_op_t op;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] mask;
    logic use_mask;
  } vrh_cmd_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic transfer_output_enable_n;
    logic mask_select_write_enable_n;
    logic serial_enable_n;
    logic [ROW_W-1:0] addr;
  } vrh_pins_t;

  localparam vrh_pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1,
    transfer_output_enable_n: 1'b1, mask_select_write_enable_n: 1'b1,
    serial_enable_n: 1'b1, addr: '0};

  typedef struct packed {
    vrh_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [3:0] init_left;
    vrh_cmd_t cmd;
    vrh_pins_t pins;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe_n;
    logic [DQ_W-1:0] dq_s1;
    logic [DQ_W-1:0] dq_s2;
    logic [DQ_W-1:0] rdata;
    logic rvalid;
    logic [ROW_W-1:0] ref_row;
    logic buf_out;
  } vrh_regs_t;

  typedef struct packed {
    logic [REFI_W-1:0] tick;
    logic [PEND_W-1:0] pend;
  } vrh_ref_t;

endpackage

// ---- src/vrh_refresh.sv ----
/*
  refresh scheduler: interval timer and pending-refresh counter.
  assumes done_in pulses once per finished refresh cycle.
*/
`timescale 1ns/1ps
module vrh_refresh import vrh_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic done_in,
  output logic need_out,
  output logic urgent_out
);

  vrh_ref_t r;
  vrh_ref_t next_r;
  logic tick_hit;

  always_comb begin
    next_r = r;
    tick_hit = (r.tick == '0);
    // one refresh owed every row interval
    if (tick_hit) begin
      next_r.tick = REFI_W'(C_REFI - 1); // RULE_15
    end else begin
      next_r.tick = r.tick - 1'b1;
    end
    case ({tick_hit && (r.pend != PEND_MAX), done_in && (r.pend != '0)})
      2'b10: next_r.pend = r.pend + 1'b1; // RULE_27
      2'b01: next_r.pend = r.pend - 1'b1;
      default: next_r.pend = r.pend;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{tick: REFI_W'(C_REFI - 1), pend: '0};
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign need_out = (r.pend != '0);
  assign urgent_out = (r.pend >= PEND_URGENT);

  no_lost_tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_15
    tick_hit && ce_in |-> r.pend != PEND_MAX)
    else $error("refresh interval dropped with pending counter full");

  urgent_need_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_27
    urgent_out |-> need_out && r.pend >= PEND_URGENT)
    else $error("urgent refresh without pending refresh");

endmodule

// ---- testbench/vrh_dev_model.sv ----
/*
  behavioural model of the video dram random port.
  assumes strobes come from host registers; data line resolved outside.
*/
`timescale 1ns/1ps
module vrh_dev_model import vrh_pkg::*; (
  input wire vrh_pins_t pins_in,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic drive_out
);
  logic [DQ_W-1:0] mem [0:(1<<(ROW_W+COL_W))-1];
  logic [ROW_W-1:0] row = '0;
  logic [ROW_W-1:0] cbr_row = '0;
  logic [COL_W-1:0] col = '0;
  logic [DQ_W-1:0] wmask = '1;
  logic xfer = 0, rd_ok = 0, ro = 0, buf_out = 0;
  int n_cbr = 0, n_ro = 0, n_act = 0;
  int xq[$];

  task automatic put;
    mem[{row, col}] = (mem[{row, col}] & ~wmask) | (dq_in & wmask);
  endtask

  always @(negedge pins_in.ras_n) begin
    if (!pins_in.cas_n) begin
      cbr_row = cbr_row + 9'h1;
      n_cbr++;
    end else begin
      row = pins_in.addr;
      n_act++;
      ro = 1;
      xfer = !pins_in.transfer_output_enable_n;
      wmask = pins_in.mask_select_write_enable_n ? '1 : dq_in;
      if (xfer) begin
        xq.push_back(pins_in.mask_select_write_enable_n ? 1 :
          (pins_in.serial_enable_n ? 3 : 2));
      end
    end
  end

  always @(posedge pins_in.ras_n) begin
    wmask = '1;
    if (ro) n_ro++;
    ro = 0;
  end

  always @(negedge pins_in.cas_n) begin
    ro = 0;
    if (!pins_in.ras_n && !xfer) begin
      #1;
      col = pins_in.addr;
      rd_ok = pins_in.mask_select_write_enable_n;
      if (!pins_in.mask_select_write_enable_n) put();
    end
  end

  always @(negedge pins_in.mask_select_write_enable_n) begin
    if (!pins_in.ras_n && !pins_in.cas_n && !xfer) begin
      #1;
      rd_ok = 0;
      put();
    end
  end

  always @(posedge pins_in.cas_n) rd_ok = 0;
  always @(posedge pins_in.transfer_output_enable_n) begin
    if (xfer) buf_out = (xq[$] == 1);
  end

  // drives only with cas and oe low after a read cas, held through hidden refresh
  assign drive_out = !pins_in.cas_n && !pins_in.transfer_output_enable_n
    && rd_ok;
  assign dq_out = mem[{row, col}];
endmodule

// ---- testbench/vrh_ctrl_tb.sv ----
/*
  self-checking bench for the video dram host controller.
  assumes the device model above stands on the far side.
*/
`timescale 1ns/1ps
module vrh_ctrl_tb import vrh_pkg::*; ;
  logic clk_in = 0, rst_in = 1, ce_in = 1, cmd_valid_in = 0, row_only = 0;
  vrh_cmd_t cmd_in = '0;
  logic cmd_ready_out, rdata_valid_out, init_done_out, oe_n, d_drv;
  logic [DQ_W-1:0] rdata_out, c_dq, d_dq, line, v;
  logic [DQ_W-1:0] last_dq = '0;
  vrh_pins_t pins;
  int n_mismatch = 0, checks_done = 0, cyc = 0, k;
  logic [DQ_W-1:0] rq[$];

  vrh_ctrl #(.PAUSE_CYCLES(20)) vrh_ctrl_i (.clk_in(clk_in),
    .rst_in(rst_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .refresh_row_only_in(row_only), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out), .init_done_out(init_done_out),
    .pins_out(pins), .mask_data_pins_in(line),
    .mask_data_pins_out(c_dq), .mask_data_pins_oe_n_out(oe_n));
  vrh_dev_model vrh_dev_model_i (.pins_in(pins), .dq_in(line),
    .dq_out(d_dq), .drive_out(d_drv));

  always #5 clk_in = ~clk_in;
  // released line shows the inverse of its last level
  assign line = d_drv ? d_dq : (!oe_n ? c_dq : ~last_dq);

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_in) begin
    last_dq <= line;
    cyc++;
    if (rdata_valid_out === 1'b1) rq.push_back(rdata_out);
    if (d_drv === 1'b1 && oe_n === 1'b0) check("bus clash", 1, 0);
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  function automatic vrh_cmd_t mk(vrh_op_t op, int r, int c, int d,
    int m, bit um);
    return '{op, r[8:0], c[8:0], d[3:0], m[3:0], um};
  endfunction

  function automatic logic [3:0] memat(int r, int c);
    return vrh_dev_model_i.mem[{r[8:0], c[8:0]}];
  endfunction

  task automatic send(input vrh_cmd_t c);
    int n;
    n = 0;
    @(negedge clk_in);
    cmd_in = c;
    cmd_valid_in = 1'b1;
    @(posedge clk_in);
    while (cmd_ready_out !== 1'b1 && n < 500) begin
      n++;
      @(posedge clk_in);
    end
    if (n >= 500) check("command taken", 0, 1);
  endtask

  task automatic rel;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
  endtask

  task automatic wait_q(input int cnt);
    int n;
    n = 0;
    while (rq.size() < cnt && n < 100) begin
      n++;
      @(posedge clk_in);
    end
    if (rq.size() < cnt) check("read pulse", 0, 1);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (pins.ras_n !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk_in);
    end
    while (!(pins.ras_n === 1'b1 && pins.cas_n === 1'b1) && n < 200) begin
      n++;
      @(posedge clk_in);
    end
    @(negedge clk_in);
  endtask

  task automatic rd(input vrh_cmd_t c, output logic [3:0] d);
    send(c);
    rel();
    wait_q(1);
    d = rq.pop_front();
  endtask

  task automatic wr(input vrh_cmd_t c);
    send(c);
    rel();
    wait_done();
  endtask

  task automatic t_init;
    repeat (5) @(negedge clk_in);
    check("ras idle", pins.ras_n, 1);
    check("dq released", oe_n, 1);
    rst_in = 0;
    k = 0;
    while (init_done_out !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clk_in);
    end
    check("init done", init_done_out, 1);
    check("init cycles", vrh_dev_model_i.n_cbr, 8);
    $display("test init finished");
  endtask

  task automatic t_rw;
    int r[4] = '{0, 511, 1, 256};
    int c[4] = '{0, 511, 510, 1};
    int d[4] = '{5, 10, 3, 12};
    for (int i = 0; i < 4; i++) begin
      wr(mk(OP_WRITE, r[i], c[i], d[i], 0, 0));
      check("early write", memat(r[i], c[i]), d[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(mk(OP_READ, r[i], c[i], 0, 0, 0), v);
      check("read word", v, d[i]);
    end
    $display("test read write finished");
  endtask

  task automatic t_mask;
    wr(mk(OP_WRITE, 7, 7, 4'ha, 0, 0));
    wr(mk(OP_WRITE, 7, 7, 4'h5, 4'h3, 1));
    check("masked write", memat(7, 7), 4'h9);
    wr(mk(OP_WRITE, 7, 7, 4'h6, 4'h3, 0));
    check("mask dropped", memat(7, 7), 4'h6);
    $display("test mask finished");
  endtask

  task automatic t_rmw;
    wr(mk(OP_WRITE, 9, 3, 4'h6, 0, 0));
    rd(mk(OP_RMW, 9, 3, 4'h9, 0, 0), v);
    check("rmw old word", v, 4'h6);
    wait_done();
    check("rmw new word", memat(9, 3), 4'h9);
    $display("test rmw finished");
  endtask

  task automatic t_hold;
    k = vrh_dev_model_i.n_act;
    @(negedge clk_in);
    ce_in = 1'b0;
    cmd_in = mk(OP_READ, 9, 3, 0, 0, 0);
    cmd_valid_in = 1'b1;
    repeat (40) @(negedge clk_in);
    check("frozen row", vrh_dev_model_i.n_act - k, 0);
    cmd_valid_in = 1'b0;
    ce_in = 1'b1;
    rd(mk(OP_READ, 9, 3, 0, 0, 0), v);
    check("thawed read", v, 4'h9);
    $display("test hold finished");
  endtask

  task automatic t_hid;
    k = vrh_dev_model_i.n_cbr;
    for (int i = 0; i < 100 && vrh_dev_model_i.n_cbr == k; i++) begin
      rd(mk(OP_READ, 9, 3, 0, 0, 0), v);
      check("hidden read", v, 4'h9);
    end
    wait_done();
    check("hidden refresh", vrh_dev_model_i.n_cbr > k, 1);
    $display("test hidden finished");
  endtask

  task automatic t_xfer;
    int x;
    x = vrh_dev_model_i.xq.size();
    send(mk(OP_RD_XFER, 20, 100, 0, 0, 0));
    rel();
    send(mk(OP_WR_XFER, 21, 3, 0, 0, 0));
    rel();
    k = 0;
    while (vrh_dev_model_i.xq.size() < x + 3 && k < 300) begin
      k++;
      @(posedge clk_in);
    end
    wait_done();
    check("read transfer", vrh_dev_model_i.xq[x], 1);
    check("pseudo write", vrh_dev_model_i.xq[x+1], 3);
    check("write transfer", vrh_dev_model_i.xq[x+2], 2);
    $display("test transfer finished");
  endtask

  task automatic t_ref;
    k = vrh_dev_model_i.n_cbr;
    repeat (C_REFI + 100) @(negedge clk_in);
    check("cbr refresh", vrh_dev_model_i.n_cbr > k, 1);
    row_only = 1;
    k = vrh_dev_model_i.n_ro;
    repeat (C_REFI + 100) @(negedge clk_in);
    check("row refresh", vrh_dev_model_i.n_ro > k, 1);
    row_only = 0;
    $display("test refresh finished");
  endtask

  task automatic t_page;
    k = vrh_dev_model_i.n_act;
    send(mk(OP_READ, 9, 3, 0, 0, 0));
    send(mk(OP_WRITE, 9, 5, 4'he, 0, 0));
    rel();
    wait_q(1);
    check("page read", rq.pop_front(), 4'h9);
    wait_done();
    check("page write", memat(9, 5), 4'he);
    check("one row open", vrh_dev_model_i.n_act - k, 1);
    $display("test page finished");
  endtask

  initial begin
    t_init();
    t_rw();
    t_mask();
    t_rmw();
    t_hold();
    t_hid();
    t_xfer();
    t_ref();
    t_page();
    summarize();
  end
endmodule
